/* bench/fault_host.sv */
// host model issuing single-word monitor reads
`timescale 1ns/1ns
`default_nettype none
module fault_host (
  // clock
  input  wire logic        clock_i,
  // read port towards the bank
  output logic             rd_req_o,
  output logic [15:0]      rd_addr_o,
  input  wire logic        rd_ack_i,
  input  wire logic        rd_err_i,
  input  wire logic [15:0] rd_data_i
);
  // idle values from time zero
  initial begin
    rd_req_o  = 1'b0;
    rd_addr_o = 16'h0000;
  end
  // one-cycle request, then a bounded wait for the answer
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
    int n;
    @(posedge clock_i);
    rd_req_o  <= 1'b1;
    rd_addr_o <= a;
    @(posedge clock_i);
    rd_req_o  <= 1'b0;
    rd_addr_o <= ~a;  // a stale address would hide decode slips
    // the answer is registered: take it as this edge samples it
    for (n = 0; n < 3; n++) begin
      @(posedge clock_i);
      if (rd_ack_i === 1'b1) break;
    end
    d = rd_data_i;
    e = (n < 3) ? rd_err_i : 1'bx;  // no answer poisons the compare
  endtask : rd
endmodule : fault_host
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the fault trace history bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fault_trace_pkg::*;
  logic        clock_i         = 1'b0;
  logic        sys_rst_i       = 1'b1;
  logic        fault_valid_i   = 1'b0;
  logic [15:0] fault_code_i    = 16'h0000;
  logic        fault_active_i  = 1'b0;
  snapshot_s   live_i          = '0;
  logic [15:0] rated_current_i = 16'h0001;
  logic        rd_req_i;
  logic        rd_ack_o;
  logic        rd_err_o;
  logic [15:0] rd_addr_i;
  logic [15:0] rd_data_o;
  int          err_count       = 0;
  int          samples_checked = 0;
  logic [15:0] hc [10]         = '{default: 16'h0000};  // expected codes
  logic [15:0] hh [10]         = '{default: 16'h0000};  // expected hours
  snapshot_s   snap            = '0;
  logic [15:0] last            = 16'h0000;
  logic [15:0] adr [17] = '{16'h0082, 16'h0083, 16'h0084, 16'h0086, 16'h0087, 16'h0088, 16'h008a, 16'h008b,
    16'h008c, 16'h008d, 16'h07e0, 16'h07e1, 16'h07e2, 16'h008e, 16'h3008, 16'h3009, 16'h300a};
  // 25 MHz clock
  always #20 clock_i = ~clock_i;
  fault_trace_history_bank DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .fault_valid_i(fault_valid_i),
    .fault_code_i(fault_code_i), .fault_active_i(fault_active_i), .live_i(live_i),
    .rated_current_i(rated_current_i), .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i),
    .rd_ack_o(rd_ack_o), .rd_err_o(rd_err_o), .rd_data_o(rd_data_o));
  fault_host HOST (.clock_i(clock_i), .rd_req_o(rd_req_i), .rd_addr_o(rd_addr_i),
    .rd_ack_i(rd_ack_o), .rd_err_i(rd_err_o), .rd_data_i(rd_data_o));
  // compare seen against expected
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // read one word and compare error flag plus data
  task automatic rc(input logic [15:0] a, input logic [16:0] exp);
    logic [15:0] d;
    logic        e;
    HOST.rd(a, d, e);
    chk({e, d}, exp);
  endtask : rc
  // one fault event with random live values
  task automatic flt(input logic [15:0] c);
    snapshot_s s;
    for (int i = 0; i < 17; i++) begin
      s[16*i +: 16] = 16'($urandom);
    end
    @(posedge clock_i);
    fault_valid_i <= 1'b1;
    fault_code_i  <= c;
    live_i        <= s;
    @(posedge clock_i);
    fault_valid_i <= 1'b0;
    fault_code_i  <= ~c;
    live_i        <= ~s;  // live values move on, so late capture shows
    for (int i = 9; i > 0; i--) begin
      hc[i] = hc[i-1];
      hh[i] = hh[i-1];
    end
    hc[0] = c;
    hh[0] = s.run_hours;
    snap  = s;
    last  = c;
  endtask : flt
  // expected snapshot word, current rescaled to 8192 at rated
  function automatic logic [15:0] word(input int i);
    logic [31:0] p;
    p = {16'h0000, snap[271-16*i -: 16]} * 32'h00002000;
    if (i != 2) return snap[271-16*i -: 16];
    if (rated_current_i == 16'h0000) return 16'h0000;
    return 16'(p / {16'h0000, rated_current_i});
  endfunction : word
  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(32'h05bfc884));
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rc(16'h0080, 17'h00000);
    rc(16'h0809, 17'h00000);
    $display("test reset done");
    @(posedge clock_i);
    fault_active_i  <= 1'b1;
    rated_current_i <= 16'(($urandom % 32'hffff) + 1);
    // twelve faults overflow the ten slots
    for (int k = 0; k < 12; k++) begin
      flt(k == 5 ? 16'hffff : 16'($urandom));
      rc(16'h0081, {1'b0, hc[0]});
    end
    rc(16'h0080, {1'b0, last});
    for (int i = 0; i < 10; i++) begin
      rc(16'h0800 + 16'(i), {1'b0, hc[i]});
      if (i < 4) begin
        rc(16'h0090 + 16'(i), {1'b0, hc[i]});
        rc(16'h0094 + 16'(i), {1'b0, hh[i]});
        rc(16'h080a + 16'(i), {1'b0, hh[i]});
      end
    end
    $display("test history done");
    for (int i = 0; i < 17; i++) begin
      rc(adr[i], {1'b0, word(i)});
    end
    $display("test snapshot done");
    // corners: unmapped holes, zero rating, fault cleared
    rc(16'h0085, 17'h10000);
    rc(16'h0089, 17'h10000);
    @(posedge clock_i);
    rated_current_i <= snap.out_current;  // rating equal to the captured current
    rc(16'h0084, {1'b0, (snap.out_current == 16'h0000) ? 16'h0000 : 16'h2000});
    @(posedge clock_i);
    rated_current_i <= 16'h0000;
    fault_active_i  <= 1'b0;
    rc(16'h0084, 17'h00000);
    rc(16'h0080, 17'h00000);
    rc(16'h0081, {1'b0, hc[0]});
    $display("test corners done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire

/* hdl/fault_trace_defines.svh */
// register addresses and constants for the fault trace history bank
`ifndef FAULT_TRACE_DEFINES_SVH
`define FAULT_TRACE_DEFINES_SVH
`define A_ACTIVE_CODE   16'h0080
`define A_PRIOR_CODE    16'h0081
`define A_FREQ_REF      16'h0082
`define A_OUT_FREQ      16'h0083
`define A_OUT_CURRENT   16'h0084
`define A_OUT_VOLTAGE   16'h0086
`define A_LINK_VOLTAGE  16'h0087
`define A_OUT_POWER     16'h0088
`define A_INPUT_PINS    16'h008a
`define A_OUTPUT_PINS   16'h008b
`define A_RUN_STATE     16'h008c
`define A_RUN_HOURS     16'h008d
`define A_HEATSINK      16'h008e
`define A_HIST_CODE_LO  16'h0090
`define A_HIST_HOURS_LO 16'h0094
`define A_RAMP_REF      16'h07e0
`define A_TORQUE_CUR    16'h07e1
`define A_FLUX_CUR      16'h07e2
`define A_HIST_CODE_HI  16'h0800
`define A_HIST_HOURS_HI 16'h080a
`define A_STAMP_YEAR    16'h3008
`define A_STAMP_MD      16'h3009
`define A_STAMP_HM      16'h300a
`define HIST_DEPTH      10
`define HIST_LOW_SLOTS  4
`define RATED_SCALE     17'h02000
`define ZERO_WORD       16'h0000
`endif

/* hdl/fault_trace_history_bank.sv */
// fault snapshot and ten-entry fault history with a read port
`timescale 1ns/1ns
`default_nettype none
`include "fault_trace_defines.svh"
module fault_trace_history_bank
  import fault_trace_pkg::*;
#(
  parameter int DEPTH = `HIST_DEPTH  // number of history slots
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // fault event from the detection logic
  input  wire logic        fault_valid_i,   // one-cycle pulse per new fault
  input  wire logic [15:0] fault_code_i,
  input  wire logic        fault_active_i,  // a fault is present now
  // live operating values
  input  wire snapshot_s   live_i,          // current field is in amperes
  input  wire logic [15:0] rated_current_i, // rated current, same scale
  // read port of the serial monitor
  input  wire logic        rd_req_i,
  input  wire logic [15:0] rd_addr_i,
  output logic             rd_ack_o,
  output logic             rd_err_o,
  output logic [15:0]      rd_data_o
);

  // operation in brief:
  // - a one-cycle pulse on fault_valid_i freezes the live values, pushes the
  //   new code into slot 0 and ages every other slot by one
  // - snapshot, prior code and history move on the same edge, so a read can
  //   never see a half-updated record
  // - reads are answered one cycle after the request, from registers only
  // - a read in the capture cycle still returns the record before the fault
  // - hours of slots 4 to 9 are kept for the shift but have no address
  // - the current word is rescaled on the read path, not at capture, so a
  //   later change of the rating shows at once without a new fault
  // limitation: a rating of zero reads the current word as zero

  // whole state of the block
  typedef struct packed {
    logic [15:0]              active_code;  // code of the fault present now
    logic [15:0]              prior_code;   // code of the last recorded fault
    snapshot_s                snap;         // live values frozen at the fault
    hist_entry_s [DEPTH-1:0]  hist;         // slot 0 newest, last slot oldest
    read_ans_s                ans;          // registered read answer
  } state_s;

  state_s s_q;  // registered state
  state_s s_d;  // next state

  // current rescale: reading of 8192 means rated current
  logic [31:0] scaled_cur;  // wide product before division
  logic [15:0] cur_bus;     // bus view of captured current

  // divide by rated; zero rating reads as zero to avoid a divide fault
  always_comb begin
    scaled_cur = {16'h0000, s_q.snap.out_current} * {15'h0000, `RATED_SCALE};
    if (rated_current_i == `ZERO_WORD) begin
      cur_bus = `ZERO_WORD;
    end else begin
      cur_bus = 16'(scaled_cur / {16'h0000, rated_current_i});
    end
  end

  // slot index width; follows the depth so a deeper history still decodes
  localparam int IDX_W = $clog2(DEPTH);

  // index helpers for the aliased history ranges
  logic [15:0] off_lo_code;   // offset into low code range
  logic [15:0] off_hi_code;   // offset into high code range
  logic [15:0] off_lo_hours;  // offset into low hours range
  logic [15:0] off_hi_hours;  // offset into high hours range

  always_comb begin
    off_lo_code  = rd_addr_i - `A_HIST_CODE_LO;
    off_hi_code  = rd_addr_i - `A_HIST_CODE_HI;
    off_lo_hours = rd_addr_i - `A_HIST_HOURS_LO;
    off_hi_hours = rd_addr_i - `A_HIST_HOURS_HI;
  end

  // next state: capture, history shift and read decode
  always_comb begin
    s_d = s_q;
    s_d.ans.ack = 1'b0;
    s_d.ans.err = 1'b0;
    // active code follows the detector; clears when fault is gone
    if (fault_valid_i) begin
      s_d.active_code = fault_code_i;
    end else if (!fault_active_i) begin
      s_d.active_code = `ZERO_WORD;
    end
    // one-cycle capture keeps snapshot and history consistent
    if (fault_valid_i) begin
      s_d.prior_code = fault_code_i;
      s_d.snap       = live_i;
      for (int i = DEPTH - 1; i > 0; i--) begin
        s_d.hist[i] = s_q.hist[i-1];  // oldest falls off
      end
      s_d.hist[0].code  = fault_code_i;
      s_d.hist[0].hours = live_i.run_hours;
    end
    // read decode; data held until the next read
    if (rd_req_i) begin
      s_d.ans.ack = 1'b1;
      // snapshot words come straight from flip-flops; only current is rescaled
      case (rd_addr_i)
        `A_ACTIVE_CODE:  s_d.ans.data = s_q.active_code;
        `A_PRIOR_CODE:   s_d.ans.data = s_q.prior_code;
        `A_FREQ_REF:     s_d.ans.data = s_q.snap.freq_ref;
        `A_OUT_FREQ:     s_d.ans.data = s_q.snap.out_freq;
        `A_OUT_CURRENT:  s_d.ans.data = cur_bus;
        `A_OUT_VOLTAGE:  s_d.ans.data = s_q.snap.out_voltage;
        `A_LINK_VOLTAGE: s_d.ans.data = s_q.snap.link_voltage;
        `A_OUT_POWER:    s_d.ans.data = s_q.snap.out_power;
        `A_INPUT_PINS:   s_d.ans.data = s_q.snap.input_pins;
        `A_OUTPUT_PINS:  s_d.ans.data = s_q.snap.output_pins;
        `A_RUN_STATE:    s_d.ans.data = s_q.snap.run_state;
        `A_RUN_HOURS:    s_d.ans.data = s_q.snap.run_hours;
        `A_HEATSINK:     s_d.ans.data = s_q.snap.heatsink_temp;
        `A_RAMP_REF:     s_d.ans.data = s_q.snap.ramp_speed_ref;
        `A_TORQUE_CUR:   s_d.ans.data = s_q.snap.torque_current;
        `A_FLUX_CUR:     s_d.ans.data = s_q.snap.flux_current;
        `A_STAMP_YEAR:   s_d.ans.data = s_q.snap.stamp_year;
        `A_STAMP_MD:     s_d.ans.data = s_q.snap.stamp_month_day;
        `A_STAMP_HM:     s_d.ans.data = s_q.snap.stamp_hour_min;
        default: begin
          // history ranges, then unmapped
          if (off_lo_code < `HIST_LOW_SLOTS) begin
            s_d.ans.data = s_q.hist[off_lo_code[IDX_W-1:0]].code;
          end else if (off_hi_code < DEPTH) begin
            s_d.ans.data = s_q.hist[off_hi_code[IDX_W-1:0]].code;
          end else if (off_lo_hours < `HIST_LOW_SLOTS) begin
            s_d.ans.data = s_q.hist[off_lo_hours[IDX_W-1:0]].hours;
          end else if (off_hi_hours < `HIST_LOW_SLOTS) begin
            s_d.ans.data = s_q.hist[off_hi_hours[IDX_W-1:0]].hours;
          end else begin
            s_d.ans.data = `ZERO_WORD;  // unmapped reads zero
            s_d.ans.err  = 1'b1;
          end
        end
      endcase
    end
  end

  // state register; empty history reads as code zero
  // reset loads constants only, so no capture survives a reset
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign rd_ack_o  = s_q.ans.ack;
  assign rd_err_o  = s_q.ans.err;
  assign rd_data_o = s_q.ans.data;

  // checks
  // every property samples on the rising edge and is off while reset is high;
  // inputs move just after an edge, so the sampled values are settled ones

  // a new fault is taken on this edge
  sequence fault_seen;
    fault_valid_i;
  endsequence

  // no new fault on this edge
  sequence fault_idle;
    !fault_valid_i;
  endsequence

  // a read of one register is taken on this edge
  sequence read_at(logic [15:0] a);
    rd_req_i && rd_addr_i == a;
  endsequence

  // capture: snapshot, codes and history move on one edge
  // prior code takes the new code
  a_prior_code_cap: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_seen |=> (s_q.prior_code == $past(fault_code_i)))
    else $error("prior code not captured");
  // newest slot takes the new code
  a_hist_head_cap: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_seen |=> (s_q.hist[0].code == $past(fault_code_i)))
    else $error("newest history slot wrong");
  // slot 0 ages into slot 1
  a_hist_shift_one: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_seen |=> (s_q.hist[1] == $past(s_q.hist[0])))
    else $error("history did not shift");
  // last slot takes the one before, oldest is lost
  a_hist_last_slot: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_seen |=> (s_q.hist[DEPTH-1] == $past(s_q.hist[DEPTH-2])))
    else $error("oldest slot not replaced");
  // history and snapshot hold without a fault
  a_hist_hold_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !fault_valid_i |=> $stable(s_q.hist) && $stable(s_q.snap))
    else $error("capture changed without fault");
  // hours in snapshot and newest slot agree
  a_snap_hours_cap: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_seen |=> (s_q.snap.run_hours == $past(live_i.run_hours)) && (s_q.hist[0].hours == s_q.snap.run_hours))
    else $error("hours capture inconsistent");
  // whole snapshot taken on the fault edge
  a_snap_all_cap: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_seen |=> s_q.snap == $past(live_i))
    else $error("snapshot not captured");
  // active code follows a new fault
  a_active_code_set: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_seen |=> s_q.active_code == $past(fault_code_i))
    else $error("active code not set");
  // active code clears once no fault is present
  a_active_code_clr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_idle ##0 !fault_active_i |=> s_q.active_code == `ZERO_WORD)
    else $error("active code not cleared");
  // active code holds while the fault stays
  a_active_code_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_idle ##0 fault_active_i |=> $stable(s_q.active_code))
    else $error("active code moved");
  // prior code holds between faults
  a_prior_code_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_idle |=> $stable(s_q.prior_code))
    else $error("prior code moved");
  // a middle slot ages by one as well
  a_hist_mid_shift: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fault_seen |=> s_q.hist[`HIST_LOW_SLOTS] == $past(s_q.hist[`HIST_LOW_SLOTS-1]))
    else $error("middle slot did not shift");

  // read path: each word answers one cycle after its request
  // active code word
  a_active_code_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_ACTIVE_CODE) |=> rd_ack_o && rd_data_o == $past(s_q.active_code))
    else $error("active code read wrong");
  // prior code word
  a_prior_code_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_PRIOR_CODE) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.prior_code))
    else $error("prior code read wrong");
  // frequency reference word
  a_freq_ref_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_FREQ_REF) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.freq_ref))
    else $error("frequency reference read wrong");
  // output frequency word
  a_out_freq_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_OUT_FREQ) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.out_freq))
    else $error("output frequency read wrong");
  // zero rating reads the current as zero
  a_zero_rating_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_OUT_CURRENT) ##0 rated_current_i == `ZERO_WORD |=> rd_ack_o && rd_data_o == `ZERO_WORD)
    else $error("zero rating current read wrong");
  // rated current reads as full scale
  a_full_scale_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_OUT_CURRENT) ##0 (rated_current_i != `ZERO_WORD && s_q.snap.out_current == rated_current_i)
    |=> rd_ack_o && rd_data_o == 16'(`RATED_SCALE))
    else $error("full scale current read wrong");
  // output voltage word
  a_out_volt_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_OUT_VOLTAGE) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.out_voltage))
    else $error("output voltage read wrong");
  // link voltage word
  a_link_volt_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_LINK_VOLTAGE) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.link_voltage))
    else $error("link voltage read wrong");
  // output power word
  a_out_power_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_OUT_POWER) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.out_power))
    else $error("output power read wrong");
  // input pin word
  a_input_pins_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_INPUT_PINS) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.input_pins))
    else $error("input pin word read wrong");
  // output pin word
  a_output_pins_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_OUTPUT_PINS) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.output_pins))
    else $error("output pin word read wrong");
  // run state word
  a_run_state_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_RUN_STATE) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.run_state))
    else $error("run state read wrong");
  // run hours word
  a_run_hours_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_RUN_HOURS) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.run_hours))
    else $error("run hours read wrong");
  // ramp limited speed reference word
  a_ramp_ref_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_RAMP_REF) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.ramp_speed_ref))
    else $error("ramp reference read wrong");
  // torque axis current word
  a_torque_cur_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_TORQUE_CUR) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.torque_current))
    else $error("torque current read wrong");
  // flux axis current word
  a_flux_cur_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_FLUX_CUR) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.flux_current))
    else $error("flux current read wrong");
  // heatsink temperature word
  a_heatsink_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_HEATSINK) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.heatsink_temp))
    else $error("heatsink read wrong");
  // stamp year word
  a_stamp_year_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_STAMP_YEAR) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.stamp_year))
    else $error("stamp year read wrong");
  // stamp month and day word
  a_stamp_md_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_STAMP_MD) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.stamp_month_day))
    else $error("stamp month day read wrong");
  // stamp hour and minute word
  a_stamp_hm_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_STAMP_HM) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.snap.stamp_hour_min))
    else $error("stamp hour minute read wrong");
  // newest code through the alias range
  a_alias_code_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_HIST_CODE_HI) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.hist[0].code))
    else $error("history alias mismatch");
  // newest code through the low range
  a_low_code_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_HIST_CODE_LO) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.hist[0].code))
    else $error("low history code wrong");
  // fifth code follows the alias range
  a_fifth_code_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_HIST_CODE_HI + 16'(`HIST_LOW_SLOTS)) |=> rd_data_o == $past(s_q.hist[`HIST_LOW_SLOTS].code))
    else $error("fifth history code wrong");
  // newest hours through the low range
  a_low_hours_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_HIST_HOURS_LO) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.hist[0].hours))
    else $error("low history hours wrong");
  // newest hours through the alias range
  a_alias_hours_rd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    read_at(`A_HIST_HOURS_HI) |=> rd_ack_o && !rd_err_o && rd_data_o == $past(s_q.hist[0].hours))
    else $error("alias history hours wrong");

  // handshake: one answer per request, unmapped reads flag and give zero
  // no answer without a request
  a_ack_one_cycle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !rd_req_i |=> !rd_ack_o)
    else $error("ack without request");
  // every request gets its answer next cycle
  a_ack_every_req: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    rd_req_i |=> rd_ack_o)
    else $error("request not answered");
  // an error answer carries zero data
  a_err_reads_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    rd_err_o |-> rd_ack_o && rd_data_o == `ZERO_WORD)
    else $error("error answer not zero");

endmodule : fault_trace_history_bank
`default_nettype wire

/* hdl/fault_trace_pkg.sv */
// types for the fault trace history bank
package fault_trace_pkg;
  // snapshot of operating values taken at fault time
  typedef struct packed {
    logic [15:0] freq_ref;
    logic [15:0] out_freq;
    logic [15:0] out_current;
    logic [15:0] out_voltage;
    logic [15:0] link_voltage;
    logic [15:0] out_power;
    logic [15:0] input_pins;
    logic [15:0] output_pins;
    logic [15:0] run_state;
    logic [15:0] run_hours;
    logic [15:0] ramp_speed_ref;
    logic [15:0] torque_current;
    logic [15:0] flux_current;
    logic [15:0] heatsink_temp;
    logic [15:0] stamp_year;
    logic [15:0] stamp_month_day;
    logic [15:0] stamp_hour_min;
  } snapshot_s;
  // one history slot
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] hours;
  } hist_entry_s;
  // read port answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] data;
  } read_ans_s;
endpackage : fault_trace_pkg
